// file: srp_pkg.sv
// constants, types and register map for the receive port mode configuration block
//
// Notes on behaviour
// RULE1 - packet mode forward channel uses 40-bit frames with video, control and diagnostics.
// RULE2 - raw pixel modes use 28-bit forward frames at a lower line rate.
// RULE3 - synchronous packet mode: line 160x, pixel clock 4x, back channel 2x reference.
// RULE4 - non-synchronous packet mode: line about 80x serializer clock, back channel 10 Mbps.
// RULE5 - packet forward line rate is independent of the CSI-2 output rate.
// RULE6 - each packet-mode receive port accepts line rates up to 4.16 Gbps.
// RULE7 - packet mode remaps incoming virtual channel IDs per receive port.
// RULE8 - raw mode builds CSI-2 stream with programmable VC and data type per port.
// RULE9 - twelve-bit high mode: 12+2 bits, 37.5-100 MHz, line = pclk*2/3*28.
// RULE10 - twelve-bit low mode: 12+2 bits, 25-50 MHz, line = pclk*28.
// RULE11 - ten-bit mode: 10+2 bits, 50-100 MHz, line = pclk/2*28.
// RULE12 - sensor changes syncs at most once per 10 pixel clocks in ten-bit mode.
// RULE13 - all raw modes run the back channel at 2.5 Mbps, default on selection.
// RULE14 - selecting packet mode defaults the back channel to 50 Mbps.
// RULE15 - writing 010 to rate select at 0x58[2:0] gives 10 Mbps back channel.
// RULE16 - strap levels 0/4 packet, 1/5 twelve-low, 2/6 twelve-high, 3/7 ten-bit.
// RULE17 - strapped receive mode is readable and writable at 0x6D[1:0].
// RULE18 - output interleaves streams as packets tagged by unique virtual channel.
// RULE19 - single CSI-2 transmit port with up to four lanes at 1.6 Gbps.
// RULE20 - control channel serves traffic continuously, never waiting for blanking.
// RULE21 - strap is sampled once after reset and held until software overwrites.
package srp_pkg;

  // ****************************************
  // register map
  // ****************************************
  localparam logic [7:0] REG_BC_RATE   = 8'h58;
  localparam logic [7:0] REG_RX_MODE   = 8'h6D;
  localparam logic [7:0] REG_VC_REMAP0 = 8'h70;
  localparam logic [7:0] REG_RAW_CFG0  = 8'h74;
  localparam logic [7:0] REG_STATUS    = 8'h78;
  localparam logic [7:0] REG_CSI_LANES = 8'h79;
  localparam logic [6:0] I2C_DEV_ADDR  = 7'h3D;  // arbitrary value

  localparam int ST_OVERFLOW = 0;
  localparam int ST_NONSYNC  = 1;
  localparam int ST_FRAME40  = 2;

  typedef enum logic [1:0] {MODE_PACKET, MODE_TWELVE_LOW, MODE_TWELVE_HIGH, MODE_TEN} srp_mode_t;

  // ****************************************
  // rates and frame lengths
  // ****************************************
  localparam logic [2:0]  BC_SEL_2P5       = 3'h0;
  localparam logic [2:0]  BC_SEL_10        = 3'h2;
  localparam logic [2:0]  BC_SEL_50        = 3'h6;
  localparam logic [15:0] BC_KBPS_2P5      = 16'h09C4;  // 2500
  localparam logic [15:0] BC_KBPS_10       = 16'h2710;  // 10000
  localparam logic [15:0] BC_KBPS_50       = 16'hC350;  // 50000
  localparam logic [5:0]  FRAME_BITS_PKT   = 6'h28;     // 40
  localparam logic [5:0]  FRAME_BITS_RAW   = 6'h1C;     // 28
  localparam logic [7:0]  LINE_MULT_SYNC   = 8'hA0;     // 160
  localparam logic [7:0]  LINE_MULT_ASYNC  = 8'h50;     // 80
  localparam logic [7:0]  LINE_MULT_RAW    = 8'h1C;     // 28
  localparam logic [2:0]  PCLK_MULT_SYNC   = 3'h4;
  localparam logic [2:0]  PCLK_MULT_ASYNC  = 3'h2;
  localparam logic [2:0]  BC_MULT_SYNC     = 3'h2;
  localparam logic [15:0] MAX_LINE_MBPS    = 16'h1040;  // 4160
  localparam logic [15:0] CSI_LANE_MBPS    = 16'h0640;  // 1600
  localparam logic [1:0]  CSI_LANES_MAX    = 2'h3;      // lane count minus one
  // pixel clock limits in tenths of MHz
  localparam logic [11:0] PCLK_HIGH_MIN    = 12'h177;
  localparam logic [11:0] PCLK_HIGH_MAX    = 12'h3E8;
  localparam logic [11:0] PCLK_LOW_MIN     = 12'h0FA;
  localparam logic [11:0] PCLK_LOW_MAX     = 12'h1F4;
  localparam logic [11:0] PCLK_TEN_MIN     = 12'h1F4;
  localparam logic [11:0] PCLK_TEN_MAX     = 12'h3E8;
  localparam logic [11:0] PIX_MASK_TEN     = 12'h3FF;
  localparam logic [11:0] PIX_MASK_TWELVE  = 12'hFFF;
  localparam int          FIFO_DEPTH       = 8;

  typedef struct packed {
    logic [1:0]  port;
    logic [1:0]  vc;
    logic [5:0]  dt;
    logic [11:0] pixel;
    logic        lineSync;
    logic        frameSync;
  } srp_link_in_t;

  typedef struct packed {
    logic [1:0]  vc;
    logic [5:0]  dt;
    logic        frameSync;
    logic        lineSync;
    logic [11:0] pixel;
  } srp_word_t;

  typedef struct packed {
    srp_mode_t   mode;
    logic [5:0]  frameBits;
    logic [2:0]  bcSel;
    logic [15:0] bcKbps;
    logic [7:0]  lineMult;
    logic [2:0]  pclkMult;
    logic [2:0]  bcMult;
    logic [1:0]  pclkNum;
    logic [1:0]  pclkDen;
    logic [11:0] pclkMin;
    logic [11:0] pclkMax;
    logic [15:0] maxLineMbps;
    logic [1:0]  csiLanes;
    logic [15:0] laneMbps;
  } srp_link_cfg_t;

endpackage

// file: srp_port_mode_config.sv
// receive port mode configuration: strap decode, i2c registers, link capture and output fifo
`timescale 1ns/1ps

// ****************************************
// output fifo
// ****************************************
module srp_fifo #(
  parameter int WIDTH = 22,
  parameter int DEPTH = 8
) (
  input  wire logic             clk,
  input  wire logic             rstN,
  input  wire logic [WIDTH-1:0] inData,
  input  wire logic             inValid,
  output logic                  inReady,
  output logic [WIDTH-1:0]      outData,
  output logic                  outValid,
  input  wire logic             outReady
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wrPtr;
  logic [AW:0]      rdPtr;
  wire              full  = (wrPtr[AW] != rdPtr[AW]) && (wrPtr[AW-1:0] == rdPtr[AW-1:0]);
  wire              empty = (wrPtr == rdPtr);
  wire              doWr  = inValid && !full;
  wire              doRd  = outReady && !empty;

  assign inReady  = !full;
  assign outValid = !empty;
  assign outData  = mem[rdPtr[AW-1:0]];

  always_ff @(posedge clk) begin
    if (doWr) begin
      mem[wrPtr[AW-1:0]] <= inData;
    end
  end

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      wrPtr <= '0;
      rdPtr <= '0;
    end else begin
      wrPtr <= wrPtr + (AW+1)'(doWr);
      rdPtr <= rdPtr + (AW+1)'(doRd);
    end
  end
endmodule

// ****************************************
// top
// ****************************************
module srp_port_mode_config (
  input  wire logic                   sys_clk,
  input  wire logic                   resetn,
  input  wire logic                   i2cSclIn,
  input  wire logic                   i2cSdaIn,
  output logic                        i2cSdaOut,
  output logic                        i2cSdaOe,
  input  wire logic [2:0]             modeStrapLevel,
  input  wire logic                   recoveredPixelClock,
  input  wire srp_pkg::srp_link_in_t  linkIn,
  output srp_pkg::srp_word_t          csiWord,
  output logic                        csiValid,
  input  wire logic                   csiReady,
  output srp_pkg::srp_link_cfg_t      linkCfg,
  output logic                        overflow
);

  // ****************************************
  // reset and input synchronisers
  // ****************************************
  logic [1:0]           rstSync;
  logic                 rstN;
  logic                 sclMeta, sclS, sclD, sdaMeta, sdaS, sdaD;
  logic [2:0]           strapMeta, strapS;
  logic                 pclkMeta, pclkS, pclkD;
  srp_pkg::srp_link_in_t linkMeta, linkS;

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      rstSync <= 2'h0;
    end else begin
      rstSync <= {rstSync[0], 1'b1};
    end
  end
  assign rstN = rstSync[1];

  // link pins carry no reset; data is aligned with the sampled clock by equal depth
  always_ff @(posedge sys_clk) begin
    linkMeta  <= linkIn;
    linkS     <= linkMeta;
    strapMeta <= modeStrapLevel;
    strapS    <= strapMeta;
  end

  always_ff @(posedge sys_clk or negedge rstN) begin
    if (!rstN) begin
      {sclMeta, sclS, sclD} <= 3'h7;
      {sdaMeta, sdaS, sdaD} <= 3'h7;
      {pclkMeta, pclkS, pclkD} <= 3'h0;
    end else begin
      {sclMeta, sclS, sclD} <= {i2cSclIn, sclMeta, sclS};
      {sdaMeta, sdaS, sdaD} <= {i2cSdaIn, sdaMeta, sdaS};
      {pclkMeta, pclkS, pclkD} <= {recoveredPixelClock, pclkMeta, pclkS};
    end
  end

  // ****************************************
  // i2c slave, served independent of video
  // ****************************************
  typedef enum logic [3:0] {I_IDLE, I_ADDR, I_ACKA, I_WREG, I_ACKR, I_WDAT, I_ACKW, I_RDAT, I_ACKRD} srp_i2c_t;
  srp_i2c_t    i2cState;
  logic [7:0]  shiftReg;
  logic [3:0]  bitCnt;
  logic        rwBit;
  logic        masterAck;
  logic [7:0]  regPtr;
  logic        regWr;
  logic [7:0]  regWrData;
  logic [7:0]  readData;

  wire startCond = sclS && sdaD && !sdaS;
  wire stopCond  = sclS && !sdaD && sdaS;
  wire sclRise   = sclS && !sclD;
  wire sclFall   = !sclS && sclD;
  wire byteDone  = (bitCnt == 4'h8);
  wire addrHit   = (shiftReg[7:1] == srp_pkg::I2C_DEV_ADDR);

  always_ff @(posedge sys_clk or negedge rstN) begin
    if (!rstN) begin
      i2cState  <= I_IDLE;
      shiftReg  <= 8'h00;
      bitCnt    <= 4'h0;
      rwBit     <= 1'b0;
      masterAck <= 1'b0;
      regPtr    <= 8'h00;
      regWr     <= 1'b0;
      regWrData <= 8'h00;
      i2cSdaOe  <= 1'b0;
    end else begin
      regWr <= 1'b0;
      if (startCond) begin // RULE20
        i2cState <= I_ADDR;
        bitCnt   <= 4'h0;
        i2cSdaOe <= 1'b0;
      end else if (stopCond) begin
        i2cState <= I_IDLE;
        i2cSdaOe <= 1'b0;
      end else if (sclRise) begin
        bitCnt <= bitCnt + 4'h1;
        if (i2cState == I_ADDR || i2cState == I_WREG || i2cState == I_WDAT) begin
          shiftReg <= {shiftReg[6:0], sdaS};
        end
        if (i2cState == I_ACKRD) begin
          masterAck <= !sdaS;
        end
      end else if (sclFall) begin
        case (i2cState)
          I_ADDR: begin
            if (byteDone) begin
              i2cState <= addrHit ? I_ACKA : I_IDLE;
              i2cSdaOe <= addrHit;
              rwBit    <= shiftReg[0];
            end
          end
          I_WREG: begin
            if (byteDone) begin
              i2cState <= I_ACKR;
              regPtr   <= shiftReg;
              i2cSdaOe <= 1'b1;
            end
          end
          I_WDAT: begin
            if (byteDone) begin
              i2cState  <= I_ACKW;
              regWr     <= 1'b1;
              regWrData <= shiftReg;
              i2cSdaOe  <= 1'b1;
            end
          end
          I_ACKA, I_ACKR, I_ACKW: begin
            bitCnt <= 4'h0;
            if (i2cState == I_ACKW) begin
              regPtr <= regPtr + 8'h01;
            end
            if (i2cState == I_ACKA && rwBit) begin
              i2cState <= I_RDAT;
              shiftReg <= readData;
              i2cSdaOe <= !readData[7];
            end else begin
              i2cState <= (i2cState == I_ACKA) ? I_WREG : I_WDAT;
              i2cSdaOe <= 1'b0;
            end
          end
          I_RDAT: begin
            if (byteDone) begin
              i2cState <= I_ACKRD;
              i2cSdaOe <= 1'b0;
              regPtr   <= regPtr + 8'h01;
            end else begin
              shiftReg <= {shiftReg[6:0], 1'b0};
              i2cSdaOe <= !shiftReg[6];
            end
          end
          I_ACKRD: begin
            bitCnt   <= 4'h0;
            i2cState <= masterAck ? I_RDAT : I_IDLE;
            shiftReg <= readData;
            i2cSdaOe <= masterAck && !readData[7];
          end
          I_IDLE: begin
            i2cSdaOe <= 1'b0;
          end
          default: begin
            i2cState <= I_IDLE;
            i2cSdaOe <= 1'b0;
          end
        endcase
      end
    end
  end

  // open drain: only ever pulls low
  always_ff @(posedge sys_clk or negedge rstN) begin
    if (!rstN) begin
      i2cSdaOut <= 1'b0;
    end else begin
      i2cSdaOut <= 1'b0;
    end
  end

  // ****************************************
  // registers
  // ****************************************
  function automatic logic inRange(input logic [7:0] a, input logic [7:0] base);
    return (a >= base) && (a < base + 8'h04);
  endfunction

  srp_pkg::srp_mode_t rxMode;
  logic [2:0]         bcSel;
  logic [7:0]         vcRemap [4];
  logic [7:0]         rawCfg [4];
  logic [1:0]         csiLanes;
  logic               strapDone;
  logic               pushDrop;

  wire writeMode  = regWr && (regPtr == srp_pkg::REG_RX_MODE);
  wire writeBc    = regWr && (regPtr == srp_pkg::REG_BC_RATE);
  wire writeStat  = regWr && (regPtr == srp_pkg::REG_STATUS);
  wire writeLanes = regWr && (regPtr == srp_pkg::REG_CSI_LANES);
  wire [1:0] ptrIdx = regPtr[1:0];
  wire srp_pkg::srp_mode_t newMode = !strapDone ? srp_pkg::srp_mode_t'(strapS[1:0])
                                                 : srp_pkg::srp_mode_t'(regWrData[1:0]);
  wire modeLoad = !strapDone || writeMode;
  wire nonSync  = (rxMode == srp_pkg::MODE_PACKET) && (bcSel == srp_pkg::BC_SEL_10);
  wire [7:0] statusByte = {5'h00, rxMode == srp_pkg::MODE_PACKET, nonSync, overflow};

  assign readData = (regPtr == srp_pkg::REG_BC_RATE)   ? {5'h00, bcSel} :
                    (regPtr == srp_pkg::REG_RX_MODE)   ? {6'h00, rxMode} :
                    inRange(regPtr, srp_pkg::REG_VC_REMAP0) ? vcRemap[ptrIdx] :
                    inRange(regPtr, srp_pkg::REG_RAW_CFG0)  ? rawCfg[ptrIdx] :
                    (regPtr == srp_pkg::REG_STATUS)    ? statusByte :
                    (regPtr == srp_pkg::REG_CSI_LANES) ? {6'h00, csiLanes} : 8'h00;

  always_ff @(posedge sys_clk or negedge rstN) begin
    if (!rstN) begin
      rxMode    <= srp_pkg::MODE_PACKET;
      bcSel     <= srp_pkg::BC_SEL_50;
      strapDone <= 1'b0;
      csiLanes  <= srp_pkg::CSI_LANES_MAX;
    end else begin
      strapDone <= 1'b1; // RULE21
      if (modeLoad) begin
        rxMode <= newMode; // RULE16 RULE17
        bcSel  <= (newMode == srp_pkg::MODE_PACKET) ? srp_pkg::BC_SEL_50 : srp_pkg::BC_SEL_2P5; // RULE13 RULE14
      end else if (writeBc) begin
        bcSel <= regWrData[2:0]; // RULE15
      end
      if (writeLanes) begin
        csiLanes <= regWrData[1:0]; // RULE19
      end
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_port
      always_ff @(posedge sys_clk or negedge rstN) begin
        if (!rstN) begin
          vcRemap[gi] <= 8'hE4;  // identity map
          rawCfg[gi]  <= 8'h00;
        end else begin
          if (regWr && regPtr == srp_pkg::REG_VC_REMAP0 + 8'(gi)) begin
            vcRemap[gi] <= regWrData;
          end
          if (regWr && regPtr == srp_pkg::REG_RAW_CFG0 + 8'(gi)) begin
            rawCfg[gi] <= regWrData;
          end
        end
      end
    end
  endgenerate

  // sticky: a new drop wins over a write-one clear in the same cycle
  always_ff @(posedge sys_clk or negedge rstN) begin
    if (!rstN) begin
      overflow <= 1'b0;
    end else begin
      overflow <= pushDrop || (overflow && !(writeStat && regWrData[srp_pkg::ST_OVERFLOW]));
    end
  end

  // ****************************************
  // link capture into the fifo
  // ****************************************
  wire pclkEdge = pclkS && !pclkD;
  wire isPacket = (rxMode == srp_pkg::MODE_PACKET);
  wire [7:0] portMap = vcRemap[linkS.port];
  wire [7:0] portRaw = rawCfg[linkS.port];
  wire [1:0] mappedVc = portMap[{linkS.vc, 1'b0} +: 2];
  wire [11:0] pixMask = (rxMode == srp_pkg::MODE_TEN) ? srp_pkg::PIX_MASK_TEN : srp_pkg::PIX_MASK_TWELVE;
  srp_pkg::srp_word_t pushWord;
  logic fifoInReady;
  srp_pkg::srp_word_t fifoOut;
  logic fifoOutValid;
  wire  takeOut = fifoOutValid && (!csiValid || csiReady);

  assign pushWord.vc        = isPacket ? mappedVc : portRaw[7:6]; // RULE7 RULE8 RULE18
  assign pushWord.dt        = isPacket ? linkS.dt : portRaw[5:0]; // RULE8
  assign pushWord.frameSync = linkS.frameSync;
  assign pushWord.lineSync  = linkS.lineSync;
  assign pushWord.pixel     = linkS.pixel & pixMask; // RULE11
  assign pushDrop           = pclkEdge && !fifoInReady;

  srp_fifo #(
    .WIDTH ($bits(srp_pkg::srp_word_t)),
    .DEPTH (srp_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk      (sys_clk),
    .rstN     (rstN),
    .inData   (pushWord),
    .inValid  (pclkEdge),
    .inReady  (fifoInReady),
    .outData  (fifoOut),
    .outValid (fifoOutValid),
    .outReady (!csiValid || csiReady)
  );

  always_ff @(posedge sys_clk or negedge rstN) begin
    if (!rstN) begin
      csiValid <= 1'b0;
      csiWord  <= '0;
    end else if (!csiValid || csiReady) begin
      csiValid <= fifoOutValid;
      if (takeOut) begin
        csiWord <= fifoOut;
      end
    end
  end

  // ****************************************
  // derived link configuration
  // ****************************************
  srp_pkg::srp_link_cfg_t next_linkCfg;
  always_comb begin
    next_linkCfg             = '0;
    next_linkCfg.mode        = rxMode;
    next_linkCfg.bcSel       = bcSel;
    next_linkCfg.maxLineMbps = srp_pkg::MAX_LINE_MBPS; // RULE6
    next_linkCfg.csiLanes    = csiLanes;
    next_linkCfg.laneMbps    = srp_pkg::CSI_LANE_MBPS; // RULE19
    if (isPacket) begin
      // line rate follows the serializer clock only, never the csi side
      next_linkCfg.frameBits = srp_pkg::FRAME_BITS_PKT; // RULE1 RULE5
      next_linkCfg.lineMult  = nonSync ? srp_pkg::LINE_MULT_ASYNC : srp_pkg::LINE_MULT_SYNC; // RULE3 RULE4
      next_linkCfg.pclkMult  = nonSync ? srp_pkg::PCLK_MULT_ASYNC : srp_pkg::PCLK_MULT_SYNC;
      next_linkCfg.bcMult    = nonSync ? 3'h0 : srp_pkg::BC_MULT_SYNC;
      next_linkCfg.bcKbps    = nonSync ? srp_pkg::BC_KBPS_10 :
                               (bcSel == srp_pkg::BC_SEL_2P5) ? srp_pkg::BC_KBPS_2P5 : srp_pkg::BC_KBPS_50;
      next_linkCfg.pclkNum   = 2'h1;
      next_linkCfg.pclkDen   = 2'h1;
    end else begin
      next_linkCfg.frameBits = srp_pkg::FRAME_BITS_RAW; // RULE2
      next_linkCfg.lineMult  = srp_pkg::LINE_MULT_RAW;
      next_linkCfg.bcKbps    = srp_pkg::BC_KBPS_2P5; // RULE13
      case (rxMode)
        srp_pkg::MODE_TWELVE_HIGH: begin // RULE9
          next_linkCfg.pclkNum = 2'h2;
          next_linkCfg.pclkDen = 2'h3;
          next_linkCfg.pclkMin = srp_pkg::PCLK_HIGH_MIN;
          next_linkCfg.pclkMax = srp_pkg::PCLK_HIGH_MAX;
        end
        srp_pkg::MODE_TWELVE_LOW: begin // RULE10
          next_linkCfg.pclkNum = 2'h1;
          next_linkCfg.pclkDen = 2'h1;
          next_linkCfg.pclkMin = srp_pkg::PCLK_LOW_MIN;
          next_linkCfg.pclkMax = srp_pkg::PCLK_LOW_MAX;
        end
        default: begin // RULE11
          next_linkCfg.pclkNum = 2'h1;
          next_linkCfg.pclkDen = 2'h2;
          next_linkCfg.pclkMin = srp_pkg::PCLK_TEN_MIN;
          next_linkCfg.pclkMax = srp_pkg::PCLK_TEN_MAX;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rstN) begin
    if (!rstN) begin
      linkCfg <= '0;
    end else begin
      linkCfg <= next_linkCfg;
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rstN);

  strap_capture_a: assert property ( // RULE16
    strapDone && !$past(strapDone) |-> rxMode == srp_pkg::srp_mode_t'($past(strapS[1:0], 1)))
    else $error("mode not taken from strap");
  strap_hold_a: assert property ( // RULE21
    strapDone && !writeMode |=> $stable(rxMode))
    else $error("mode changed without a write");
  raw_bc_rate_a: assert property ( // RULE13
    rxMode != srp_pkg::MODE_PACKET |=> linkCfg.bcKbps == srp_pkg::BC_KBPS_2P5)
    else $error("raw back channel not 2.5 Mbps");
  frame_len_a: assert property ( // RULE1
    rxMode == srp_pkg::MODE_PACKET |=> linkCfg.frameBits == srp_pkg::FRAME_BITS_PKT)
    else $error("packet frame not 40 bits");
  raw_frame_a: assert property ( // RULE2
    rxMode != srp_pkg::MODE_PACKET |=> linkCfg.frameBits == srp_pkg::FRAME_BITS_RAW)
    else $error("raw frame not 28 bits");
  nonsync_rate_a: assert property ( // RULE15
    nonSync |=> linkCfg.bcKbps == srp_pkg::BC_KBPS_10 && linkCfg.lineMult == srp_pkg::LINE_MULT_ASYNC)
    else $error("non-synchronous rates wrong");
  pkt_default_a: assert property ( // RULE14
    writeMode && regWrData[1:0] == 2'h0 |=> bcSel == srp_pkg::BC_SEL_50 ##1 linkCfg.bcKbps == srp_pkg::BC_KBPS_50)
    else $error("packet mode did not default to 50 Mbps");
  vc_remap_a: assert property ( // RULE7
    pclkEdge && fifoInReady && isPacket |-> pushWord.vc == vcRemap[linkS.port][2*linkS.vc +: 2])
    else $error("virtual channel not remapped");
  ten_mask_a: assert property ( // RULE11
    pclkEdge && rxMode == srp_pkg::MODE_TEN |-> pushWord.pixel[11:10] == 2'h0)
    else $error("ten-bit pixel has upper bits");
  csi_hold_a: assert property ( // RULE18
    csiValid && !csiReady |=> csiValid && $stable(csiWord))
    else $error("csi word dropped under stall");
  drop_flag_a: assert property (
    pclkEdge && !fifoInReady |=> overflow)
    else $error("drop not flagged");

  packet_push_c: cover property (pclkEdge && fifoInReady && isPacket);
  raw_push_c:    cover property (pclkEdge && fifoInReady && rxMode != srp_pkg::MODE_PACKET);
  mode_write_c:  cover property (writeMode ##[1:1000] writeBc);
  fifo_full_c:   cover property (!fifoInReady ##1 csiValid && csiReady);

endmodule

// file: srp_serializer_model.sv
// serializer stand-in: pixel clock and link word
`timescale 1ns/1ps
module srp_serializer_model (
  input  wire logic             run,
  output logic                  pclk,
  output srp_pkg::srp_link_in_t link
);
  // syncs held still, so the ten-bit sync spacing is always kept
  // upper pixel bits set so a missing ten-bit mask shows up
  // clock stands still between bursts; word changes on the falling edge only
  initial begin
    pclk = 1'b0;
    link = '{port: 2'h0, vc: 2'h1, dt: 6'h2B, pixel: 12'hC00, lineSync: 1'b0, frameSync: 1'b0};
    forever begin
      #80;
      if (run || pclk) begin
        pclk = !pclk;
        if (!pclk) link.pixel = link.pixel + 12'h001;
      end
    end
  end
endmodule

// file: srp_port_mode_config_bench.sv
// bench for the receive port mode block: strap, registers, link capture
`timescale 1ns/1ps
module srp_port_mode_config_bench;
  logic sys_clk = 1'b0, resetn = 1'b0, scl = 1'b1, sdaDrv = 1'b1, run = 1'b0, csiReady = 1'b0;
  logic [2:0]             modeStrapLevel = 3'h0;
  logic                   pclk, sdaOe, csiValid, overflow;
  logic [7:0]             rdData;
  srp_pkg::srp_link_in_t  linkIn;
  srp_pkg::srp_word_t     csiWord;
  srp_pkg::srp_link_cfg_t linkCfg;
  int                     bad_count = 0, compares = 0, words = 0;
  // per mode code: packet, twelve-low, twelve-high, ten-bit
  logic [15:0]            pratio [4] = '{16'h0005, 16'h0005, 16'h000B, 16'h0006};
  logic [15:0]            pmin [4] = '{16'h0000, 16'h00FA, 16'h0177, 16'h01F4};
  logic [15:0]            pmax [4] = '{16'h0000, 16'h01F4, 16'h03E8, 16'h03E8};
  // open-drain data line with pull-up
  wire sda = sdaDrv & !sdaOe;
  always #2 sys_clk = !sys_clk;
  srp_serializer_model partner (.run(run), .pclk(pclk), .link(linkIn));
  srp_port_mode_config dut (.sys_clk(sys_clk), .resetn(resetn), .i2cSclIn(scl), .i2cSdaIn(sda), .i2cSdaOut(),
    .i2cSdaOe(sdaOe), .modeStrapLevel(modeStrapLevel), .recoveredPixelClock(pclk), .linkIn(linkIn),
    .csiWord(csiWord), .csiValid(csiValid), .csiReady(csiReady), .linkCfg(linkCfg), .overflow(overflow));
  task automatic hc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic sbit(input logic b, output logic r);
    sdaDrv <= b;
    hc(10);
    scl <= 1'b1;
    hc(10);
    r = sda;
    scl <= 1'b0;
    hc(10);
  endtask
  task automatic wbyte(input logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) sbit(d[i], r);
    sbit(1'b1, r);
    chk("ack", 16'(r), 16'h0000);
  endtask
  task automatic start();
    sdaDrv <= 1'b1;
    hc(10);
    scl <= 1'b1;
    hc(10);
    sdaDrv <= 1'b0;
    hc(10);
    scl <= 1'b0;
    hc(10);
  endtask
  task automatic stop();
    sdaDrv <= 1'b0;
    hc(10);
    scl <= 1'b1;
    hc(10);
    sdaDrv <= 1'b1;
    hc(10);
  endtask
  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    start();
    wbyte(8'h7A);
    wbyte(a);
    wbyte(d);
    stop();
    hc(4);
  endtask
  task automatic rst();
    resetn <= 1'b0;
    hc(12);
    resetn <= 1'b1;
    hc(10);
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    logic r;
    // every strap level, each sampled fresh out of reset
    for (int lv = 0; lv < 8; lv++) begin
      modeStrapLevel <= 3'(lv);
      rst();
      chk("mode", 16'(linkCfg.mode), 16'(lv % 4));
      chk("bc rate", linkCfg.bcKbps, lv % 4 == 0 ? srp_pkg::BC_KBPS_50 : srp_pkg::BC_KBPS_2P5);
      chk("frame", 16'(linkCfg.frameBits), lv % 4 == 0 ? 16'h0028 : 16'h001C);
      chk("pclk ratio", 16'({linkCfg.pclkNum, linkCfg.pclkDen}), pratio[lv % 4]);
      chk("pclk min", 16'(linkCfg.pclkMin), pmin[lv % 4]);
      chk("pclk max", 16'(linkCfg.pclkMax), pmax[lv % 4]);
    end
    chk("line cap", linkCfg.maxLineMbps, 16'h1040);
    chk("lane rate", linkCfg.laneMbps, 16'h0640);
    chk("lanes", 16'(linkCfg.csiLanes), 16'h0003);
    start();
    wbyte(8'h7A);
    wbyte(8'h6D);
    start();
    wbyte(8'h7B);
    for (int i = 7; i >= 0; i--) sbit(1'b1, rdData[i]);
    sbit(1'b1, r);
    stop();
    chk("mode reg", 16'(rdData[1:0]), 16'h0003);
    wreg(8'h6D, 8'h00);
    chk("line mult", 16'(linkCfg.lineMult), 16'h00A0);
    chk("pclk mult", 16'(linkCfg.pclkMult), 16'h0004);
    chk("bc mult", 16'(linkCfg.bcMult), 16'h0002);
    wreg(8'h58, 8'h02);
    chk("async rate", linkCfg.bcKbps, 16'h2710);
    chk("async mult", 16'(linkCfg.lineMult), 16'h0050);
    // reversed remap, sink stalled until the fifo refuses
    wreg(8'h70, 8'h1B);
    run <= 1'b1;
    hc(480);
    run <= 1'b0;
    hc(50);
    chk("overflow", 16'(overflow), 16'h0001);
    chk("vc", 16'(csiWord.vc), 16'h0002);
    chk("dt", 16'(csiWord.dt), 16'h002B);
    chk("pixel", csiWord.pixel, 16'h0C00);
    csiReady <= 1'b1;
    for (int i = 0; i < 40; i++) begin
      hc(1);
      words += int'(csiValid === 1'b1 && csiReady === 1'b1);
    end
    chk("words", 16'(words), 16'(srp_pkg::FIFO_DEPTH + 1));
    wreg(8'h78, 8'h01);
    chk("overflow clear", 16'(overflow), 16'h0000);
    // ten-bit raw capture with programmed channel and type, sink always ready
    wreg(8'h6D, 8'h03);
    wreg(8'h74, 8'hDE);
    chk("raw rate", linkCfg.bcKbps, srp_pkg::BC_KBPS_2P5);
    run <= 1'b1;
    hc(60);
    run <= 1'b0;
    hc(50);
    chk("raw vc", 16'(csiWord.vc), 16'h0003);
    chk("raw dt", 16'(csiWord.dt), 16'h001E);
    chk("ten mask", 16'(csiWord.pixel[11:10]), 16'h0000);
    summarize();
  end
endmodule
